/* verilog/lam_logic_block.sv */
// logic allocator and sixteen macrocells of one logic_block_unit
//
// Operation
// - Every macrocell owns a cluster of four plus one, five product terms in all.
// - Each macrocell chooses a five-term bypass, a twenty-term route or an expanded route.
// - The block holds sixteen identical slices, one per macrocell.
// - Chains join macrocells k, k+4, k+8, k+12 with wrap, capped at 75, 80, 75, 70 terms.
// - A cluster or super cluster steered to one destination gives zero to every other one.
// - Macrocell n takes its logic input from allocator output n.
// - Each macrocell has a configurable xor and a storage element set as register or latch.
// - Each macrocell output goes to both the output routing pool and the global pool.
// - A macrocell may register its pin directly, with a delay choosing setup or zero hold.
// - The storage clock comes from an eight-way selector of block and term clocks.
`timescale 1ns/1ps
module lam_logic_block
   import lam_pkg::*;
(
   // clock and reset
   input  wire logic                                mclk,
   input  wire logic                                rstn,
   // product terms from the and array, five per cluster
   input  wire logic [LAM_NUM_PT-1:0]               product_term,
   // clocks: block clock pins and product-term clocks
   input  wire logic [LAM_NUM_BLOCK_CLK-1:0]        block_clock,
   input  wire logic                                shared_pt_clock,
   input  wire logic [LAM_NUM_MC-1:0]               mc_pt_clock,
   // direct pin inputs of the i/o cells
   input  wire logic [LAM_NUM_MC-1:0]               io_pin,
   // allocator configuration
   input  wire logic [LAM_NUM_MC*LAM_DEST_W-1:0]    cluster_dest,
   input  wire logic [LAM_NUM_MC*2-1:0]             route_sel,
   input  wire logic [LAM_NUM_MC-1:0]               chain_forward,
   // macrocell configuration
   input  wire logic [LAM_NUM_MC-1:0]               xor_invert,
   input  wire logic [LAM_NUM_MC-1:0]               latch_mode,
   input  wire logic [LAM_NUM_MC-1:0]               comb_out,
   input  wire logic [LAM_NUM_MC-1:0]               io_reg_sel,
   input  wire logic [LAM_NUM_MC-1:0]               io_zero_hold,
   input  wire logic [LAM_NUM_MC*LAM_CLK_SEL_W-1:0] clk_sel,
   // macrocell results
   output logic      [LAM_NUM_MC-1:0]               output_routing_pool,
   output logic      [LAM_NUM_MC-1:0]               global_routing_pool
);

   // cluster sums and steering
   logic [LAM_NUM_MC-1:0] cluster_sum;
   logic [LAM_DEST_W-1:0] dest     [LAM_NUM_MC];
   logic [1:0]            route    [LAM_NUM_MC];
   logic [LAM_NUM_MC-1:0] fwd_on;
   logic [LAM_NUM_MC-1:0] bypass_sum;
   logic [LAM_NUM_MC-1:0] expand_sum;
   logic [LAM_NUM_MC-1:0] expand_pipe_reg;
   logic [LAM_NUM_MC-1:0] alloc_out;

   // synchronisers for pins from outside the mclk domain
   logic [LAM_NUM_BLOCK_CLK-1:0] bclk_meta_reg;
   logic [LAM_NUM_BLOCK_CLK-1:0] bclk_sync_reg;
   logic [LAM_NUM_MC-1:0]        io_meta_reg;
   logic [LAM_NUM_MC-1:0]        io_sync_reg;

   // clock selection per macrocell
   logic [LAM_NUM_MC-1:0] sel_clk;
   logic [LAM_NUM_MC-1:0] sel_clk_prev_reg;
   logic [LAM_NUM_MC-1:0] clk_tick;
   logic [LAM_NUM_MC-1:0] mc_out;

   // block clocks and pins take two flops before any logic sees them
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bclk_meta_reg <= '0;
         bclk_sync_reg <= '0;
      end else begin
         bclk_meta_reg <= block_clock;
         bclk_sync_reg <= bclk_meta_reg;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         io_meta_reg <= '0;
         io_sync_reg <= '0;
      end else begin
         io_meta_reg <= io_pin;
         io_sync_reg <= io_meta_reg;
      end
   end

   // per-cluster sums and per-macrocell configuration fields
   genvar gc;
   generate
      for (gc = 0; gc < LAM_NUM_MC; gc++) begin : g_cluster
         // four base terms plus the extra term form one cluster
         assign cluster_sum[gc] = |product_term[gc*LAM_CLUSTER_PT +: LAM_CLUSTER_PT];
         assign dest[gc]        = cluster_dest[gc*LAM_DEST_W +: LAM_DEST_W];
         assign route[gc]       = route_sel[gc*2 +: 2];
         // a super cluster is sent down the chain only on the expanded route
         assign fwd_on[gc]      = (route[gc] == LAM_ROUTE_EXPAND) && chain_forward[gc];
         // bypass sees only the own cluster, grounded if it was steered away
         assign bypass_sum[gc]  = cluster_sum[gc] && (dest[gc] == '0);
      end
   endgenerate

   // cluster c steered with code k lands on macrocell c-k; any other
   // macrocell that could take it sees zero from it
   function automatic logic wide_sum(input int m, input int limit);
      int   c;
      logic acc;
      acc = 1'b0;
      for (int k = 0; k < LAM_WIDE_CLUSTERS; k++) begin
         c = (m + k) % LAM_NUM_MC;
         if (k < limit) begin
            acc = acc | (cluster_sum[c] && (int'(dest[c]) == k));
         end
      end
      return acc;
   endfunction

   // expanded route: gather the chain behind this macrocell while every
   // link forwards, counting clusters against the chain ceiling; the
   // unrolled form keeps the wrapped chain free of combinational loops
   always_comb begin
      int  src;
      int  lim;
      int  used;
      logic live;
      logic acc;
      src  = 0;
      lim  = 0;
      used = 0;
      live = 1'b0;
      acc  = 1'b0;
      expand_sum = '0;
      for (int m = 0; m < LAM_NUM_MC; m++) begin
         lim  = lam_chain_clusters(m % LAM_NUM_CHAINS);
         acc  = wide_sum(m, lim);
         used = LAM_WIDE_CLUSTERS;
         live = 1'b1;
         for (int h = 1; h < LAM_CHAIN_HOPS; h++) begin
            // predecessor on the chain k, k+4, k+8, k+12, wrapping
            src  = (m + LAM_NUM_MC - h*LAM_CHAIN_STEP) % LAM_NUM_MC;
            live = live && fwd_on[src];
            if (live && (used < lim)) begin
               acc = acc | wide_sum(src, lim - used);
            end
            used = used + LAM_WIDE_CLUSTERS;
         end
         expand_sum[m] = acc;
      end
   end

   // expansion costs an extra stage, like the expansion_delay of the array
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         expand_pipe_reg <= '0;
      end else begin
         expand_pipe_reg <= expand_sum;
      end
   end

   // sixteen identical slices: route choice, clock choice, macrocell
   genvar gm;
   generate
      for (gm = 0; gm < LAM_NUM_MC; gm++) begin : g_slice

         // route choice; a forwarding macrocell is grounded itself
         always_comb begin
            case (route[gm])
               LAM_ROUTE_BYPASS: alloc_out[gm] = bypass_sum[gm];
               LAM_ROUTE_WIDE:   alloc_out[gm] = wide_sum(gm, LAM_WIDE_CLUSTERS);
               LAM_ROUTE_EXPAND: alloc_out[gm] = fwd_on[gm] ? 1'b0 : expand_pipe_reg[gm];
               default:          alloc_out[gm] = bypass_sum[gm];
            endcase
         end

         // eight-way clock choice; code 7 is the inverted shared term clock
         always_comb begin
            case (clk_sel[gm*LAM_CLK_SEL_W +: LAM_CLK_SEL_W])
               LAM_CLK_BLOCK0:     sel_clk[gm] = bclk_sync_reg[0];
               LAM_CLK_BLOCK1:     sel_clk[gm] = bclk_sync_reg[1];
               LAM_CLK_BLOCK2:     sel_clk[gm] = bclk_sync_reg[2];
               LAM_CLK_BLOCK3:     sel_clk[gm] = bclk_sync_reg[3];
               LAM_CLK_SHARED:     sel_clk[gm] = shared_pt_clock;
               LAM_CLK_MC_TRUE:    sel_clk[gm] = mc_pt_clock[gm];
               LAM_CLK_MC_INV:     sel_clk[gm] = ~mc_pt_clock[gm];
               LAM_CLK_SHARED_INV: sel_clk[gm] = ~shared_pt_clock;
               default:            sel_clk[gm] = shared_pt_clock;
            endcase
         end

         // the selected clock is sampled; its rising edge becomes a tick.
         // a source faster than mclk/2 cannot be followed.
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               sel_clk_prev_reg[gm] <= LAM_SYNC_RESET;
            end else begin
               sel_clk_prev_reg[gm] <= sel_clk[gm];
            end
         end

         assign clk_tick[gm] = sel_clk[gm] && !sel_clk_prev_reg[gm];

         lam_macrocell u_mc (
            .mclk         (mclk),
            .rstn         (rstn),
            .logic_in     (alloc_out[gm]),
            .io_in_sync   (io_sync_reg[gm]),
            .clk_level    (sel_clk[gm]),
            .clk_tick     (clk_tick[gm]),
            .xor_invert   (xor_invert[gm]),
            .latch_mode   (latch_mode[gm]),
            .comb_out     (comb_out[gm]),
            .io_reg_sel   (io_reg_sel[gm]),
            .io_zero_hold (io_zero_hold[gm]),
            .out_reg      (mc_out[gm])
         );
      end
   endgenerate

   // both pools are copies of the macrocell output flop
   assign output_routing_pool = mc_out;
   assign global_routing_pool = mc_out;

endmodule

/* verilog/lam_pkg.sv */
// shared constants for the logic allocator and macrocell slice
package lam_pkg;

   // slice geometry
   localparam int LAM_NUM_MC         = 16;
   localparam int LAM_CLUSTER_BASE   = 4;
   localparam int LAM_CLUSTER_EXTRA  = 1;
   localparam int LAM_CLUSTER_PT     = LAM_CLUSTER_BASE + LAM_CLUSTER_EXTRA;
   localparam int LAM_NUM_PT         = LAM_NUM_MC * LAM_CLUSTER_PT;
   localparam int LAM_WIDE_CLUSTERS  = 4;
   localparam int LAM_DEST_W         = 2;

   // expansion chains: macrocells k, k+4, k+8, k+12, wrapping to k
   localparam int LAM_NUM_CHAINS     = 4;
   localparam int LAM_CHAIN_STEP     = 4;
   localparam int LAM_CHAIN_HOPS     = 4;
   localparam int LAM_CHAIN0_PT_MAX  = 75;
   localparam int LAM_CHAIN1_PT_MAX  = 80;
   localparam int LAM_CHAIN2_PT_MAX  = 75;
   localparam int LAM_CHAIN3_PT_MAX  = 70;

   // clock selector
   localparam int LAM_NUM_BLOCK_CLK  = 4;
   localparam int LAM_CLK_SEL_W      = 3;
   localparam logic [2:0] LAM_CLK_BLOCK0     = 3'h0;
   localparam logic [2:0] LAM_CLK_BLOCK1     = 3'h1;
   localparam logic [2:0] LAM_CLK_BLOCK2     = 3'h2;
   localparam logic [2:0] LAM_CLK_BLOCK3     = 3'h3;
   localparam logic [2:0] LAM_CLK_SHARED     = 3'h4;
   localparam logic [2:0] LAM_CLK_MC_TRUE    = 3'h5;
   localparam logic [2:0] LAM_CLK_MC_INV     = 3'h6;
   localparam logic [2:0] LAM_CLK_SHARED_INV = 3'h7;

   // reset values
   localparam logic LAM_STORE_RESET = 1'b0;
   localparam logic LAM_OUT_RESET   = 1'b0;
   localparam logic LAM_SYNC_RESET  = 1'b0;

   // allocator routes, gray along bypass -> wide -> expanded
   typedef enum logic [1:0] {
      LAM_ROUTE_BYPASS = 2'h0,
      LAM_ROUTE_WIDE   = 2'h1,
      LAM_ROUTE_EXPAND = 2'h3
   } lam_route_e;

   // clusters a chain may gather, from its product-term ceiling
   function automatic int lam_chain_clusters(input int chain);
      int pt;
      case (chain)
         0:       pt = LAM_CHAIN0_PT_MAX;
         1:       pt = LAM_CHAIN1_PT_MAX;
         2:       pt = LAM_CHAIN2_PT_MAX;
         default: pt = LAM_CHAIN3_PT_MAX;
      endcase
      return pt / LAM_CLUSTER_PT;
   endfunction

endpackage

/* verilog/lam_macrocell.sv */
// one macrocell: xor stage, register or latch, input register path
`timescale 1ns/1ps
module lam_macrocell
   import lam_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // data sources
   input  wire logic logic_in,
   input  wire logic io_in_sync,
   // selected storage clock, as level and as rising-edge tick
   input  wire logic clk_level,
   input  wire logic clk_tick,
   // configuration
   input  wire logic xor_invert,
   input  wire logic latch_mode,
   input  wire logic comb_out,
   input  wire logic io_reg_sel,
   input  wire logic io_zero_hold,
   // results
   output logic      out_reg
);

   logic xor_val;
   logic io_dly_reg;
   logic d_val;
   logic store_reg;

   // programmable xor on the allocator output
   assign xor_val = logic_in ^ xor_invert;

   // extra stage on the pin path buys zero hold at the cost of setup
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         io_dly_reg <= LAM_SYNC_RESET;
      end else begin
         io_dly_reg <= io_in_sync;
      end
   end

   // input register takes the pin directly, bypassing the allocator
   assign d_val = io_reg_sel ? (io_zero_hold ? io_dly_reg : io_in_sync) : xor_val;

   // register loads on the edge; latch follows d while the clock is high
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         store_reg <= LAM_STORE_RESET;
      end else if (latch_mode ? clk_level : clk_tick) begin
         store_reg <= d_val;
      end
   end

   // output flop; the combinational option costs one mclk of latency
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_reg <= LAM_OUT_RESET;
      end else begin
         out_reg <= comb_out ? xor_val : store_reg;
      end
   end

endmodule

/* test/lam_and_array.sv */
// model of the and array: resolved product terms presented to the allocator
`timescale 1ns/1ps
module lam_and_array
   import lam_pkg::*;
(
   // clock
   input  wire logic                  mclk,
   // resolved term levels in, the same terms out toward the block
   input  wire logic [LAM_NUM_PT-1:0] terms,
   output logic      [LAM_NUM_PT-1:0] product_term = 80'h0
);
   // terms move after the falling edge so the block only samples settled levels
   always @(negedge mclk) begin
      product_term <= terms;
   end
endmodule

/* test/lam_logic_block_assertions.sv */
// checker for the logic block: routes, chains, storage modes and clock selection
`timescale 1ns/1ps
module lam_checker
   import lam_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rstn,
   // terms, clocks and pins
   input wire logic [79:0] product_term,
   input wire logic [3:0]  block_clock,
   input wire logic        shared_pt_clock,
   input wire logic [15:0] mc_pt_clock,
   input wire logic [15:0] io_pin,
   // configuration
   input wire logic [31:0] cluster_dest,
   input wire logic [31:0] route_sel,
   input wire logic [15:0] chain_forward,
   input wire logic [15:0] xor_invert,
   input wire logic [15:0] latch_mode,
   input wire logic [15:0] comb_out,
   input wire logic [15:0] io_reg_sel,
   input wire logic [15:0] io_zero_hold,
   input wire logic [47:0] clk_sel,
   // results
   input wire logic [15:0] output_routing_pool,
   input wire logic [15:0] global_routing_pool
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // macrocell 0 views; dest codes of clusters 0..3 all zero keep its bypass sum unambiguous
   wire logic [15:0] pl = output_routing_pool;
   wire logic        d0 = (|product_term[4:0]) ^ xor_invert[0];
   wire logic        b0 = route_sel[1:0] == 2'h0 && cluster_dest[7:0] == 8'h00 && !io_reg_sel[0];
   wire logic        s0 = b0 && !comb_out[0] && !latch_mode[0] && clk_sel[2:0] == 3'h4;
   wire logic        k0 = b0 && !comb_out[0] && !latch_mode[0] && clk_sel[2:0] == 3'h0;

   a_pools_equal: assert property (pl == global_routing_pool)
      else $error("routing pools differ");
   a_release_zero: assert property ($rose(rstn) |-> pl == 16'h0000)
      else $error("outputs not clear after reset");
   a_bypass_path: assert property (
      b0 && comb_out[0] |=> pl[0] == $past(d0)) else $error("bypass route wrong");
   a_wide_path: assert property (
      route_sel[1:0] == 2'h1 && cluster_dest[7:0] == 8'he4 && comb_out[0] && !io_reg_sel[0]
      |=> pl[0] == $past((|product_term[19:0]) ^ xor_invert[0])) else $error("wide route wrong");
   a_chain_gather: assert property (
      (route_sel[9:8] == 2'h3 && route_sel[1:0] == 2'h3 && chain_forward[0] && !chain_forward[4]
       && !chain_forward[12] && cluster_dest[15:0] == 16'he4e4 && comb_out[4] && !io_reg_sel[4]
       && $stable(product_term[39:0]) && $stable(xor_invert[4])) [*3]
      |=> pl[4] == $past((|product_term[39:0]) ^ xor_invert[4])) else $error("chain sum wrong");
   a_shared_capture: assert property (
      s0 && $rose(shared_pt_clock) ##1 s0 |=> pl[0] == $past(d0, 2)) else $error("no capture");
   a_block_capture: assert property (
      k0 && $rose(block_clock[0]) ##1 k0 [*3] |=> pl[0] == $past(d0, 2))
      else $error("block clock capture wrong");
   a_latch_open: assert property (
      b0 && latch_mode[0] && !comb_out[0] && clk_sel[2:0] == 3'h4 && shared_pt_clock
      ##1 !comb_out[0] |=> pl[0] == $past(d0, 2)) else $error("latch not transparent");
   a_pin_capture: assert property (
      (io_reg_sel[0] && !comb_out[0] && !latch_mode[0] && clk_sel[2:0] == 3'h4
       && $stable(io_pin[0])) [*5] ##0 $rose(shared_pt_clock) ##1 !comb_out[0]
      |=> pl[0] == $past(io_pin[0], 2)) else $error("pin register wrong");
endmodule

bind lam_logic_block lam_checker lam_checker_i (.*);

/* test/tb.sv */
// bench for the logic block: random terms and pins through every route and clock source
`timescale 1ns/1ps
module tb;
   import lam_pkg::*;
   // design inputs, all defined from time zero
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        shared_pt_clock = 1'b0;
   logic [3:0]  block_clock = 4'h0;
   logic [79:0] terms = 80'h0;
   logic [79:0] product_term;
   logic [31:0] cluster_dest = 32'h0, route_sel = 32'h0;
   logic [47:0] clk_sel = 48'h0;
   logic [15:0] mc_pt_clock = 16'h0, io_pin = 16'h0, chain_forward = 16'h0, xor_invert = 16'h0;
   logic [15:0] latch_mode = 16'h0, comb_out = 16'h0, io_reg_sel = 16'h0, io_zero_hold = 16'h0;
   logic [15:0] output_routing_pool, global_routing_pool;
   int          errors = 0, comparisons = 0, cycles = 0;

   lam_and_array lam_and_array_i (.*);
   lam_logic_block lam_logic_block_i (.*);

   // 250 MHz clock
   always #2 mclk = ~mclk;

   // hang guard, far above the some 750 cycles the sequence needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end

   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t pools %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // source 0..3 block clocks, 4 shared term clock, 5 every per-macrocell term clock
   task automatic set_src(input int s, input logic v);
      if (s < 4) block_clock[s] = v;
      else if (s == 4) shared_pt_clock = v;
      else mc_pt_clock = {16{v}};
   endtask

   // mode 0 bypass, 1 wide, 2 expanded with macrocell 0 forwarding, 3 route code 2,
   // 4 expanded with macrocells 0..11 forwarding, so chain 0 gathers up to its ceiling
   function automatic logic [15:0] expect_comb(input int mode);
      logic [15:0] e;
      for (int m = 0; m < 16; m++) begin
         if (mode == 0 || mode == 3) e[m] = |terms[5*m+:5];
         else e[m] = (m % 4 == 0) ? |terms[5*m+:20] : 1'b0;
      end
      if (mode == 2) e[0] = 1'b0; // its sum travels on to macrocell 4
      if (mode == 2) e[4] = |terms[39:0];
      // macrocell 12 takes 15 clusters; cluster 3 lies past the 75-term ceiling
      if (mode == 4) e = {3'h0, |{terms[79:20], terms[14:0]}, 12'h0};
      return e ^ xor_invert;
   endfunction

   initial begin
      logic [15:0] prev, mask;
      int          hit;
      void'($urandom(62));
      step(12);
      rstn = 1'b1;
      // combinational view through each route, first terms are corner patterns
      comb_out = 16'hffff;
      for (int mode = 0; mode < 5; mode++) begin
         cluster_dest = (mode == 0 || mode == 3) ? 32'h0 : {4{8'he4}};
         route_sel = {16{mode == 3 ? 2'h2 : mode >= 2 ? 2'h3 : mode == 1 ? 2'h1 : 2'h0}};
         chain_forward = (mode == 2) ? 16'h0001 : (mode == 4) ? 16'h0fff : 16'h0000;
         xor_invert = 16'($urandom);
         for (int i = 0; i < 20; i++) begin
            terms = (i == 0) ? 80'h0 : (i == 1) ? 80'h1 << 39 : (i == 2) ? 80'h1 << 15
                  : {16'($urandom), $urandom, $urandom};
            io_pin = 16'($urandom);
            step(4);
            check(output_routing_pool, expect_comb(mode));
            check(global_routing_pool, expect_comb(mode));
         end
      end
      // edge registers: each source edge loads only the macrocells that select it
      comb_out = 16'h0;
      cluster_dest = 32'h0;
      route_sel = 32'h0;
      chain_forward = 16'h0;
      for (int off = 0; off < 8; off += 4) begin
         for (int m = 0; m < 16; m++) clk_sel[3*m+:3] = 3'((m + off) % 8);
         for (int e = 0; e < 12; e++) begin
            terms = {16'($urandom), $urandom, $urandom};
            step(4);
            prev = output_routing_pool;
            set_src(e / 2, e % 2 == 0);
            step(6);
            hit = (e % 2 == 0) ? e / 2 : (e == 9) ? 7 : (e == 11) ? 6 : 8;
            for (int m = 0; m < 16; m++) mask[m] = (clk_sel[3*m+:3] == hit);
            check(output_routing_pool & mask, expect_comb(0) & mask);
            check(output_routing_pool & ~mask, prev & ~mask);
         end
      end
      // latches follow while the shared clock is high and hold while it is low
      latch_mode = 16'hffff;
      clk_sel = {16{3'h4}};
      for (int i = 0; i < 6; i++) begin
         shared_pt_clock = (i % 2 == 0);
         step(2);
         prev = output_routing_pool;
         terms = {16'($urandom), $urandom, $urandom};
         step(5);
         check(output_routing_pool, (i % 2 == 0) ? expect_comb(0) : prev);
      end
      // input registers straight from the pins, with and without the hold delay
      latch_mode = 16'h0;
      io_reg_sel = 16'hffff;
      for (int i = 0; i < 4; i++) begin
         io_zero_hold = {16{i % 2 == 1}};
         io_pin = (i == 0) ? 16'hffff : 16'($urandom);
         step(8);
         shared_pt_clock = 1'b1;
         step(4);
         check(output_routing_pool, io_pin);
         shared_pt_clock = 1'b0;
         step(2);
      end
      results();
   end
endmodule
